// [core/rrs_pkg.sv]
/*
 * package for the run and reference source selector: register map, fields, reset values, enums and carriers.
 * assumes one 200 MHz clock with a synchronous active-high reset; registers are reached over AXI4-Lite.
 */
package rrs_pkg;

	// ==========================================================
	// register map
	localparam logic [3:0] RRS_OFF_CTRL = 4'h0;
	localparam logic [3:0] RRS_OFF_STAT = 4'h4;
	localparam logic [3:0] RRS_OFF_KREF = 4'h8;
	localparam logic [3:0] RRS_OFF_SREF = 4'hc;

	// ==========================================================
	// fields and reset values
	localparam logic [3:0] RRS_METHOD_MAX = 4'h8;
	localparam logic [3:0] RRS_METHOD_RESET = 4'h3;
	localparam logic [15:0] RRS_REF_RESET = 16'h0000;
	localparam int RRS_METHOD_LSB = 0;
	localparam int RRS_DISP_LSB = 16;
	localparam logic [3:0] RRS_DISP_FREF = 4'h0;
	localparam logic [1:0] RRS_RESP_OKAY = 2'b00;
	localparam logic [1:0] RRS_RESP_SLVERR = 2'b10;

	// ==========================================================
	// source and run state codes
	typedef enum logic [2:0] {
		RRS_SRC_KEYPAD = 3'b001,
		RRS_SRC_TERM = 3'b010,
		RRS_SRC_SERIAL = 3'b100
	} rrs_src_t;

	typedef enum logic [1:0] {
		RRS_ST_STOP = 2'b01,
		RRS_ST_RUN = 2'b10
	} rrs_state_t;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic runCmd;
		logic [15:0] freqRef;
	} rrs_cmd_t;

	typedef struct packed {
		rrs_src_t runSrc;
		rrs_src_t refSrc;
		logic runSourceLight;
		logic refSourceLight;
	} rrs_sel_t;

endpackage : rrs_pkg

// [core/rrs_decode.sv]
/*
 * decodes the operation method setting and the local/remote mode into run and reference sources and lights.
 * assumes the method value was already limited to 0..8 by the register writer.
 */
module rrs_decode
	import rrs_pkg::*;
(
	input wire logic localMode,
	input wire logic [3:0] operation_method_setting,
	output rrs_sel_t sel
);

	// ==========================================================
	// source table
	always_comb begin
		sel = '{RRS_SRC_KEYPAD, RRS_SRC_KEYPAD, 1'b0, 1'b0};
		if (!localMode) begin
			case (operation_method_setting)
				4'h0, 4'h2, 4'h4: sel.runSrc = RRS_SRC_KEYPAD;
				4'h1, 4'h3, 4'h5: sel.runSrc = RRS_SRC_TERM;
				default: sel.runSrc = RRS_SRC_SERIAL;
			endcase
			case (operation_method_setting)
				4'h0, 4'h1, 4'h7: sel.refSrc = RRS_SRC_KEYPAD;
				4'h2, 4'h3, 4'h8: sel.refSrc = RRS_SRC_TERM;
				default: sel.refSrc = RRS_SRC_SERIAL;
			endcase
			sel.runSourceLight = (sel.runSrc != RRS_SRC_KEYPAD);
			sel.refSourceLight = (sel.refSrc != RRS_SRC_KEYPAD);
		end
	end

endmodule : rrs_decode

// [core/rrs_selector.sv]
/*
 * run and reference source selector: picks run command and frequency reference sources and drives indicators.
 * assumes keypad and terminal inputs are synchronous to clock; software uses AXI4-Lite, one access at a time.
 */
// Our own choices: the AXI4-Lite register port and the address map.
// Contract
// - mode key toggles local/remote only when stopped
// - reset: remote, terminal run, analog reference
// - contact inputs act in both modes
// - local: keypad run and reference, lights off
// - remote: method picks run source, light
// - remote: method picks reference source, light
// - power-up: source lights on, reference display item
// - display shows current selected frequency reference
// - power-up: stopped, stop light on, run dark
module rrs_selector
	import rrs_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic modeKey,
	input wire logic keyRun,
	input wire logic keyStop,
	input wire logic termRun,
	input wire logic [15:0] voltage_reference_input,
	input wire logic [15:0] current_reference_input,
	input wire logic currentRefSelect,
	input wire logic [3:0] multi_function_contact_inputs,
	output logic [3:0] contactActions,
	output logic runCmd,
	output logic [15:0] freqRef,
	output logic [15:0] displayValue,
	output logic [3:0] displayItem,
	output logic run_source_light,
	output logic refSourceLight,
	output logic runLight,
	output logic stopLight,
	output logic localLight
);

	// ==========================================================
	// state
	logic localMode, next_localMode;
	logic [3:0] operation_method_setting, next_operation_method_setting;
	logic [15:0] keypadRef, next_keypadRef;
	logic [15:0] serialRef, next_serialRef;
	logic serialRun, next_serialRun;
	logic keyRunLatch, next_keyRunLatch;
	logic modeKeyPrev, next_modeKeyPrev;
	rrs_state_t runState, next_runState;
	rrs_sel_t sel;
	rrs_cmd_t cmd;

	// ==========================================================
	// bus slave state
	logic awHeld, next_awHeld, wHeld, next_wHeld;
	logic [3:0] awAddr, next_awAddr;
	logic [31:0] wData, next_wData;
	logic [3:0] wStrb, next_wStrb;
	logic bValid, next_bValid, rValid, next_rValid;
	logic [1:0] bResp, next_bResp, rResp, next_rResp;
	logic [31:0] rData, next_rData;
	logic doWrite, addrOk;
	logic awOk, next_awOk;
	logic awReady, wReady, arReady;

	rrs_decode u_decode (
		.localMode(localMode),
		.operation_method_setting(operation_method_setting),
		.sel(sel)
	);

	// ==========================================================
	// command selection
	always_comb begin
		cmd.runCmd = keyRunLatch;
		case (sel.runSrc)
			RRS_SRC_TERM: cmd.runCmd = termRun;
			RRS_SRC_SERIAL: cmd.runCmd = serialRun;
			default: cmd.runCmd = keyRunLatch;
		endcase
		case (sel.refSrc)
			RRS_SRC_TERM: cmd.freqRef = currentRefSelect ? current_reference_input : voltage_reference_input;
			RRS_SRC_SERIAL: cmd.freqRef = serialRef;
			default: cmd.freqRef = keypadRef;
		endcase
	end

	// ==========================================================
	// run state and mode key
	always_comb begin
		next_modeKeyPrev = modeKey;
		next_localMode = localMode;
		if (modeKey && !modeKeyPrev && runState == RRS_ST_STOP) begin
			next_localMode = !localMode;
		end
		next_keyRunLatch = keyRunLatch;
		if (keyStop) begin
			next_keyRunLatch = 1'b0;
		end else if (keyRun) begin
			next_keyRunLatch = 1'b1;
		end
		case (runState)
			RRS_ST_STOP: next_runState = cmd.runCmd ? RRS_ST_RUN : RRS_ST_STOP;
			RRS_ST_RUN: next_runState = cmd.runCmd ? RRS_ST_RUN : RRS_ST_STOP;
			default: next_runState = RRS_ST_STOP;
		endcase
	end

	// ==========================================================
	// bus slave
	assign doWrite = (awHeld || s_axi_awvalid) && (wHeld || s_axi_wvalid) && !bValid;
	assign addrOk = awHeld ? awOk : (s_axi_awaddr[31:4] == 28'h000_0000);

	always_comb begin
		logic [3:0] wa;
		logic [31:0] wd;
		logic [3:0] ws;
		wa = awHeld ? awAddr : s_axi_awaddr[3:0];
		wd = wHeld ? wData : s_axi_wdata;
		ws = addrOk ? (wHeld ? wStrb : s_axi_wstrb) : 4'h0;
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_awAddr = awAddr;
		next_awOk = awOk;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bValid = bValid && !s_axi_bready;
		next_bResp = bResp;
		next_rValid = rValid && !s_axi_rready;
		next_rResp = rResp;
		next_rData = rData;
		next_operation_method_setting = operation_method_setting;
		next_keypadRef = keypadRef;
		next_serialRef = serialRef;
		next_serialRun = serialRun;
		if (s_axi_awvalid && !awHeld) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr[3:0];
			next_awOk = addrOk;
		end
		if (s_axi_wvalid && !wHeld) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bValid = 1'b1;
			next_bResp = RRS_RESP_OKAY;
			case (wa)
				RRS_OFF_CTRL: begin
					if (ws[0] && wd[3:0] <= RRS_METHOD_MAX) begin
						next_operation_method_setting = wd[3:0];
					end else if (ws[0]) begin
						next_bResp = RRS_RESP_SLVERR;
					end
					if (ws[1]) begin
						next_serialRun = wd[8];
					end
				end
				RRS_OFF_KREF: begin
					if (ws[0]) next_keypadRef[7:0] = wd[7:0];
					if (ws[1]) next_keypadRef[15:8] = wd[15:8];
				end
				RRS_OFF_SREF: begin
					if (ws[0]) next_serialRef[7:0] = wd[7:0];
					if (ws[1]) next_serialRef[15:8] = wd[15:8];
				end
				default: next_bResp = RRS_RESP_SLVERR;
			endcase
			if (!addrOk) begin
				next_bResp = RRS_RESP_SLVERR;
			end
		end
		if (s_axi_arvalid && !rValid) begin
			next_rValid = 1'b1;
			next_rResp = RRS_RESP_OKAY;
			case (s_axi_araddr[3:0])
				RRS_OFF_CTRL: next_rData = {23'h00_0000, serialRun, 4'h0, operation_method_setting};
				RRS_OFF_STAT: next_rData = {12'h000, displayItem, 4'h0, multi_function_contact_inputs, 2'b00,
					localMode, runState == RRS_ST_RUN, runCmd, run_source_light, refSourceLight, 1'b0};
				RRS_OFF_KREF: next_rData = {16'h0000, keypadRef};
				RRS_OFF_SREF: next_rData = {16'h0000, serialRef};
				default: begin
					next_rData = 32'h0000_0000;
					next_rResp = RRS_RESP_SLVERR;
				end
			endcase
			if (s_axi_araddr[31:4] != 28'h000_0000) begin
				next_rData = 32'h0000_0000;
				next_rResp = RRS_RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clock) begin
		if (srst) begin
			localMode <= 1'b0;
			operation_method_setting <= RRS_METHOD_RESET;
			keypadRef <= RRS_REF_RESET;
			serialRef <= RRS_REF_RESET;
			serialRun <= 1'b0;
			keyRunLatch <= 1'b0;
			modeKeyPrev <= 1'b0;
			runState <= RRS_ST_STOP;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 4'h0;
			awOk <= 1'b0;
			awReady <= 1'b1;
			wReady <= 1'b1;
			arReady <= 1'b1;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			bValid <= 1'b0;
			bResp <= RRS_RESP_OKAY;
			rValid <= 1'b0;
			rResp <= RRS_RESP_OKAY;
			rData <= 32'h0000_0000;
			contactActions <= 4'h0;
			runCmd <= 1'b0;
			freqRef <= RRS_REF_RESET;
			displayValue <= RRS_REF_RESET;
			displayItem <= RRS_DISP_FREF;
			run_source_light <= 1'b1;
			refSourceLight <= 1'b1;
			runLight <= 1'b0;
			stopLight <= 1'b1;
			localLight <= 1'b0;
		end else begin
			localMode <= next_localMode;
			operation_method_setting <= next_operation_method_setting;
			keypadRef <= next_keypadRef;
			serialRef <= next_serialRef;
			serialRun <= next_serialRun;
			keyRunLatch <= next_keyRunLatch;
			modeKeyPrev <= next_modeKeyPrev;
			runState <= next_runState;
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddr <= next_awAddr;
			awOk <= next_awOk;
			awReady <= !next_awHeld;
			wReady <= !next_wHeld;
			arReady <= !next_rValid;
			wData <= next_wData;
			wStrb <= next_wStrb;
			bValid <= next_bValid;
			bResp <= next_bResp;
			rValid <= next_rValid;
			rResp <= next_rResp;
			rData <= next_rData;
			contactActions <= multi_function_contact_inputs;
			runCmd <= cmd.runCmd;
			freqRef <= cmd.freqRef;
			displayValue <= cmd.freqRef;
			displayItem <= RRS_DISP_FREF;
			run_source_light <= sel.runSourceLight;
			refSourceLight <= sel.refSourceLight;
			runLight <= next_runState == RRS_ST_RUN;
			stopLight <= next_runState == RRS_ST_STOP;
			localLight <= next_localMode;
		end
	end

	assign s_axi_awready = awReady;
	assign s_axi_wready = wReady;
	assign s_axi_bvalid = bValid;
	assign s_axi_bresp = bResp;
	assign s_axi_arready = arReady;
	assign s_axi_rvalid = rValid;
	assign s_axi_rdata = rData;
	assign s_axi_rresp = rResp;

endmodule : rrs_selector

// [sim/rrs_selector_props.sv]
/* checker for rrs_selector; bound to its ports, one clock, srst */
module rrs_selector_props
	import rrs_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic modeKey,
	input wire logic [3:0] multi_function_contact_inputs,
	input wire logic [3:0] contactActions,
	input wire logic runCmd,
	input wire logic [15:0] freqRef,
	input wire logic [15:0] displayValue,
	input wire logic [3:0] displayItem,
	input wire logic run_source_light,
	input wire logic refSourceLight,
	input wire logic runLight,
	input wire logic stopLight,
	input wire logic localLight
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	// ====
	// sequences
	sequence s_idlePress;
		$rose(modeKey) && stopLight && !runLight && !runCmd;
	endsequence
	sequence s_busyPress;
		$rose(modeKey) && runLight && runCmd;
	endsequence
	// ====
	// properties
	property p_reset;
		$fell(srst) |-> stopLight && !runLight && !localLight && run_source_light && refSourceLight;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state");
	property p_toggle;
		s_idlePress |-> ##[1:2] $changed(localLight);
	endproperty
	a_toggle: assert property (p_toggle) else $error("mode toggle");
	property p_ignore;
		s_busyPress |=> $stable(localLight) [*2];
	endproperty
	a_ignore: assert property (p_ignore) else $error("mode while running");
	property p_contacts;
		$changed(multi_function_contact_inputs) |=> contactActions == $past(multi_function_contact_inputs);
	endproperty
	a_contacts: assert property (p_contacts) else $error("contacts");
	property p_localDark;
		localLight && $past(localLight) |-> !run_source_light && !refSourceLight;
	endproperty
	a_localDark: assert property (p_localDark) else $error("local lights");
	property p_item;
		displayItem == RRS_DISP_FREF;
	endproperty
	a_item: assert property (p_item) else $error("display item");
	property p_display;
		$stable(freqRef) [*2] |-> displayValue == freqRef;
	endproperty
	a_display: assert property (p_display) else $error("display value");
	property p_run;
		$rose(runCmd) |-> ##[1:2] (runLight && !stopLight);
	endproperty
	a_run: assert property (p_run) else $error("run lights");
endmodule : rrs_selector_props

// [sim/rrs_panel.sv]
/* keypad model; clocked by the bench clock */
module rrs_panel (
	input wire logic clock,
	output logic modeKey,
	output logic keyRun,
	output logic keyStop
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{modeKey, keyRun, keyStop} = 3'h0;
	end
	// key held two cycles, then released
	task automatic press(input logic [2:0] k);
		@(posedge clock);
		{modeKey, keyRun, keyStop} <= k;
		repeat (2) @(posedge clock);
		{modeKey, keyRun, keyStop} <= 3'h0;
	endtask : press
endmodule : rrs_panel

// [sim/rrs_selector_tb_top.sv]
/* bench for rrs_selector: AXI4-Lite master tasks and keypad model */
module rrs_selector_tb_top
	import rrs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'h0;
	logic srst = 1'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic termRun = 1'h0, currentRefSelect = 1'h0;
	logic [15:0] voltage_reference_input = 16'h1234, current_reference_input = 16'h5678;
	logic [3:0] multi_function_contact_inputs = 4'h0;
	logic modeKey, keyRun, keyStop, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic runCmd, run_source_light, refSourceLight, runLight, stopLight, localLight;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd;
	logic [3:0] contactActions, displayItem;
	logic [15:0] freqRef, displayValue;
	int err_count = 0, check_count = 0, cycles = 0;
	always #2.5 clock = ~clock;
	rrs_panel panel (
		.clock(clock),
		.modeKey(modeKey),
		.keyRun(keyRun),
		.keyStop(keyStop)
	);
	rrs_selector uut (
		.clock(clock),
		.srst(srst),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.modeKey(modeKey),
		.keyRun(keyRun),
		.keyStop(keyStop),
		.termRun(termRun),
		.voltage_reference_input(voltage_reference_input),
		.current_reference_input(current_reference_input),
		.currentRefSelect(currentRefSelect),
		.multi_function_contact_inputs(multi_function_contact_inputs),
		.contactActions(contactActions),
		.runCmd(runCmd),
		.freqRef(freqRef),
		.displayValue(displayValue),
		.displayItem(displayItem),
		.run_source_light(run_source_light),
		.refSourceLight(refSourceLight),
		.runLight(runLight),
		.stopLight(stopLight),
		.localLight(localLight)
	);
	// ====
	// helpers
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic settle;
		repeat (4) @(posedge clock);
	endtask : settle
	task automatic axWrite(input logic [31:0] a, input logic [31:0] d);
		logic pa, pw;
		pa = 1'h1;
		pw = 1'h1;
		@(posedge clock);
		s_axi_awvalid <= 1'h1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'h1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'h1;
		while (pa || pw) begin
			@(posedge clock);
			if (pa && s_axi_awready) begin
				s_axi_awvalid <= 1'h0;
				pa = 1'h0;
			end
			if (pw && s_axi_wready) begin
				s_axi_wvalid <= 1'h0;
				pw = 1'h0;
			end
		end
		while (!s_axi_bvalid) @(posedge clock);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axWrite
	task automatic axRead(input logic [31:0] a);
		@(posedge clock);
		s_axi_arvalid <= 1'h1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'h1;
		do @(posedge clock); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge clock);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axRead
	// ====
	// scenarios
	task automatic t_reset;
		chk("srcLight", run_source_light, 1'h1);
		chk("refLight", refSourceLight, 1'h1);
		chk("item", displayItem, RRS_DISP_FREF);
		chk("stopLight", stopLight, 1'h1);
		chk("runLight", runLight, 1'h0);
		currentRefSelect <= 1'h1;
		termRun <= 1'h1;
		settle;
		chk("freqRef", freqRef, 16'h5678);
		chk("display", displayValue, 16'h5678);
		chk("runCmd", runCmd, 1'h1);
		currentRefSelect <= 1'h0;
	endtask : t_reset
	task automatic t_methods;
		int m;
		logic [15:0] er;
		axWrite(32'(RRS_OFF_KREF), 32'h0000_00aa);
		axWrite(32'(RRS_OFF_SREF), 32'h0000_00bb);
		for (m = 0; m < 9; m++) begin
			axWrite(32'(RRS_OFF_CTRL), 32'h0000_0100 | m);
			settle;
			er = (m < 2 || m == 7) ? 16'h00aa : (m == 2 || m == 3 || m == 8) ? 16'h1234 : 16'h00bb;
			chk("bresp", resp, RRS_RESP_OKAY);
			chk("srcLight", run_source_light, m > 5 || m % 2);
			chk("runCmd", runCmd, m > 5 || m % 2);
			chk("refLight", refSourceLight, !(m < 2 || m == 7));
			chk("freqRef", freqRef, er);
			chk("display", displayValue, er);
		end
		axWrite(32'(RRS_OFF_CTRL), 32'h0000_0003);
	endtask : t_methods
	task automatic t_reject;
		axWrite(32'(RRS_OFF_CTRL), 32'h0000_0009);
		chk("bresp", resp, RRS_RESP_SLVERR);
		axRead(32'(RRS_OFF_CTRL));
		chk("method", rd[3:0], RRS_METHOD_RESET);
		axRead(32'h0000_0010);
		chk("rresp", resp, RRS_RESP_SLVERR);
		chk("rdata", rd, 32'h0000_0000);
	endtask : t_reject
	task automatic t_local;
		termRun <= 1'h0;
		multi_function_contact_inputs <= 4'ha;
		settle;
		panel.press(3'h4);
		settle;
		chk("local", localLight, 1'h1);
		chk("srcLight", run_source_light, 1'h0);
		chk("refLight", refSourceLight, 1'h0);
		chk("freqRef", freqRef, 16'h00aa);
		chk("contacts", contactActions, 4'ha);
		termRun <= 1'h1;
		settle;
		chk("runCmd", runCmd, 1'h0);
		panel.press(3'h2);
		settle;
		chk("runCmd", runCmd, 1'h1);
		panel.press(3'h4);
		settle;
		chk("local", localLight, 1'h1);
		panel.press(3'h1);
		settle;
		panel.press(3'h4);
		settle;
		chk("local", localLight, 1'h0);
		multi_function_contact_inputs <= 4'h5;
		settle;
		chk("contacts", contactActions, 4'h5);
	endtask : t_local
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : test_done
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		repeat (4) @(posedge clock);
		srst <= 1'h0;
		@(posedge clock);
		t_reset();
		t_methods();
		t_reject();
		t_local();
		test_done();
	end
endmodule : rrs_selector_tb_top

bind rrs_selector rrs_selector_props u_props (
	.clock(clock),
	.srst(srst),
	.modeKey(modeKey),
	.multi_function_contact_inputs(multi_function_contact_inputs),
	.contactActions(contactActions),
	.runCmd(runCmd),
	.freqRef(freqRef),
	.displayValue(displayValue),
	.displayItem(displayItem),
	.run_source_light(run_source_light),
	.refSourceLight(refSourceLight),
	.runLight(runLight),
	.stopLight(stopLight),
	.localLight(localLight)
);
